// >>> rci_top.sv
/*
  Reset-class register initialiser: holds the core, timer, serial port
  and converter control registers and loads them per reset class.
  Assumes one-cycle reset-class pulses from a reset controller on CLK_I.
*/
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ns
`default_nettype none

module rci_top (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // reset classes, one-cycle pulses on CLK_I
  input wire logic POR_I,
  input wire logic BOR_I,
  input wire logic MASTER_CLEAR_I,
  input wire logic WDT_RESET_I,
  input wire logic INSTR_RESET_I,
  input wire logic STACK_FULL_I,
  input wire logic STACK_UNDER_I,
  input wire logic WAKE_WDT_I,
  input wire logic WAKE_INT_I,
  // wake-up interrupt detail
  input wire logic [rci_pkg::DATA_W-1:0] WAKE_CAUSE_I,
  input wire logic WAKE_HIGH_PRI_I,
  input wire logic [rci_pkg::PC_W-1:0] PC_I,
  // condition inputs
  input wire logic [3:0] CONV_CFG_I,
  input wire logic OSC_POR_COND_I,
  input wire logic OSC_RUN_COND_I,
  input wire logic OSC_PORT_PINS_I,
  input wire logic SBOR_KEEP_I,
  // port A pins
  input wire logic [rci_pkg::DATA_W-1:0] PORT_A_PINS_I,
  output logic [rci_pkg::DATA_W-1:0] PORT_A_LATCH_O,
  output logic [rci_pkg::DATA_W-1:0] PORT_A_DIR_O,
  // core program counter load
  output logic PC_LOAD_O,
  output logic [rci_pkg::PC_W-1:0] PC_VECTOR_O,
  // register port
  input wire logic [rci_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [rci_pkg::DATA_W-1:0] WDATA_I,
  input wire logic WE_I,
  input wire logic RE_I,
  output logic [rci_pkg::DATA_W-1:0] RDATA_O
);
  import rci_pkg::*;

  // ------------------------------------------------------------
  // reset classes
  // ------------------------------------------------------------
  logic cls_pwr;
  logic cls_hard;
  logic cls_wake;
  logic vec_wake;

  // RESET_I behaves like power-on so the block is defined from start
  assign cls_pwr = RESET_I | POR_I | BOR_I;
  assign cls_hard = MASTER_CLEAR_I | WDT_RESET_I | INSTR_RESET_I |
                    STACK_FULL_I | STACK_UNDER_I;
  assign cls_wake = WAKE_WDT_I | WAKE_INT_I;

  function automatic logic wr(input logic [4:0] a);
    wr = WE_I && (ADDR_I == a);
  endfunction : wr

  // ------------------------------------------------------------
  // timer registers
  // ------------------------------------------------------------
  logic [7:0] timer2_count_reg;
  logic [7:0] timer2_period_reg;
  logic [7:0] timer0_control_reg;
  logic [7:0] timer0_count_high_reg;
  logic [7:0] timer0_count_low_reg;
  logic [7:0] timer1_control_reg;
  logic [7:0] timer1_count_low_reg;
  logic [7:0] timer1_count_high_reg;

  always_ff @(posedge CLK_I) begin
    if (cls_pwr) begin
      timer2_count_reg <= ALL_ONES;
      timer2_period_reg <= ALL_ZEROS;
    end else if (cls_hard) begin
      timer2_count_reg <= ALL_ZEROS;
      timer2_period_reg <= PERIOD_MASK;
    end else if (cls_wake) begin
      timer2_period_reg <= PERIOD_MASK;
    end else begin
      if (wr(A_TIMER2_COUNT)) begin
        timer2_count_reg <= WDATA_I;
      end
      if (wr(A_TIMER2_PERIOD)) begin
        timer2_period_reg <= WDATA_I & PERIOD_MASK;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (cls_pwr || cls_hard) begin
      timer0_control_reg <= ALL_ONES;
      timer0_count_high_reg <= ALL_ZEROS;
    end else if (!cls_wake) begin
      if (wr(A_TIMER0_CONTROL)) begin
        timer0_control_reg <= WDATA_I;
      end
      if (wr(A_TIMER0_HIGH)) begin
        timer0_count_high_reg <= WDATA_I;
      end
    end
  end

  // low byte of timer0 and high byte of timer1 carry no reset value
  always_ff @(posedge CLK_I) begin
    if (!(cls_pwr || cls_hard || cls_wake)) begin
      if (wr(A_TIMER0_LOW)) begin
        timer0_count_low_reg <= WDATA_I;
      end
      if (wr(A_TIMER1_HIGH)) begin
        timer1_count_high_reg <= WDATA_I;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (cls_pwr) begin
      timer1_control_reg <= ALL_ZEROS;
      timer1_count_low_reg <= ALL_ZEROS;
    end else if (cls_hard) begin
      timer1_control_reg[T1_CLEAR_BIT] <= 1'b0;
    end else if (!cls_wake) begin
      if (wr(A_TIMER1_CONTROL)) begin
        timer1_control_reg <= WDATA_I;
      end
      if (wr(A_TIMER1_LOW)) begin
        timer1_count_low_reg <= WDATA_I;
      end
    end
  end

  // ------------------------------------------------------------
  // serial port and converter
  // ------------------------------------------------------------
  logic [7:0] serial_port_address_reg;
  logic [7:0] serial_port_state_reg;
  logic [7:0] serial_port_control_one_reg;
  logic [7:0] serial_port_control_two_reg;
  logic [7:0] serial_port_buffer_reg;
  logic [7:0] converter_control_zero_reg;
  logic [7:0] converter_control_one_reg;
  logic [7:0] converter_control_two_reg;
  logic [7:0] converter_result_low_reg;

  always_ff @(posedge CLK_I) begin
    if (cls_pwr || cls_hard) begin
      serial_port_address_reg <= ALL_ZEROS;
      serial_port_state_reg <= ALL_ZEROS;
      serial_port_control_one_reg <= ALL_ZEROS;
      serial_port_control_two_reg <= ALL_ZEROS;
    end else if (!cls_wake) begin
      if (wr(A_SP_ADDRESS)) begin
        serial_port_address_reg <= WDATA_I;
      end
      if (wr(A_SP_STATE)) begin
        serial_port_state_reg <= WDATA_I;
      end
      if (wr(A_SP_CONTROL_ONE)) begin
        serial_port_control_one_reg <= WDATA_I;
      end
      if (wr(A_SP_CONTROL_TWO)) begin
        serial_port_control_two_reg <= WDATA_I;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (cls_pwr) begin
      serial_port_buffer_reg <= ALL_ZEROS;
      converter_result_low_reg <= ALL_ZEROS;
    end else if (!(cls_hard || cls_wake)) begin
      if (wr(A_SP_BUFFER)) begin
        serial_port_buffer_reg <= WDATA_I;
      end
      if (wr(A_CONV_RESULT_LOW)) begin
        converter_result_low_reg <= WDATA_I;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (cls_pwr) begin
      converter_control_one_reg <= {4'h0, CONV_CFG_I};
    end else if (cls_hard) begin
      converter_control_one_reg <= ALL_ZEROS;
    end else if (!cls_wake && wr(A_CONV_CONTROL_ONE)) begin
      converter_control_one_reg <= WDATA_I & SIX_BIT_MASK;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (cls_pwr || cls_hard) begin
      converter_control_zero_reg <= ALL_ZEROS;
      converter_control_two_reg <= ALL_ZEROS;
    end else if (!cls_wake) begin
      if (wr(A_CONV_CONTROL_ZERO)) begin
        converter_control_zero_reg <= WDATA_I & SIX_BIT_MASK;
      end
      if (wr(A_CONV_CONTROL_TWO)) begin
        converter_control_two_reg <= WDATA_I & CONV2_MASK;
      end
    end
  end

  // ------------------------------------------------------------
  // oscillator, voltage detect, watchdog, reset cause
  // ------------------------------------------------------------
  logic [7:0] oscillator_control_reg;
  logic [7:0] voltage_detect_control_reg;
  logic [7:0] watchdog_control_reg;
  logic [7:0] reset_control_reg;

  always_ff @(posedge CLK_I) begin
    if (cls_pwr) begin
      oscillator_control_reg <= OSC_RESET;
      oscillator_control_reg[OSC_POR_Q_BIT] <= OSC_POR_COND_I;
    end else if (cls_hard) begin
      oscillator_control_reg <= OSC_RESET;
      oscillator_control_reg[OSC_HARD_Q_BIT] <= OSC_RUN_COND_I;
    end else if (cls_wake) begin
      // only the running-clock status bit may move on wake-up
      oscillator_control_reg[OSC_HARD_Q_BIT] <= OSC_RUN_COND_I;
    end else if (wr(A_OSC_CONTROL)) begin
      oscillator_control_reg <= WDATA_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (cls_pwr || cls_hard) begin
      voltage_detect_control_reg <= VDET_RESET;
      watchdog_control_reg <= ALL_ZEROS;
    end else if (!cls_wake) begin
      if (wr(A_VDET_CONTROL)) begin
        voltage_detect_control_reg <= WDATA_I & VDET_MASK;
      end
      if (wr(A_WDOG_CONTROL)) begin
        watchdog_control_reg <= WDATA_I & WDOG_MASK;
      end
    end
  end

  // cause flags are active low; software sets them back to one
  always_ff @(posedge CLK_I) begin
    if (cls_pwr) begin
      reset_control_reg <= RESET_CONTROL_POR;
      reset_control_reg[RC_POR_N] <= !(RESET_I || POR_I);
      reset_control_reg[RC_BOR_N] <= 1'b0;
      reset_control_reg[6] <= SBOR_KEEP_I & !(RESET_I || POR_I);
    end else if (cls_hard) begin
      reset_control_reg[7] <= 1'b0;
      reset_control_reg[RC_RI_N] <= !INSTR_RESET_I;
      reset_control_reg[RC_TO_N] <= !WDT_RESET_I;
      reset_control_reg[RC_PD_N] <= 1'b1;
    end else if (cls_wake) begin
      reset_control_reg[RC_PD_N] <= 1'b0;
      if (WAKE_WDT_I) begin
        reset_control_reg[RC_TO_N] <= 1'b0;
      end
    end else if (wr(A_RESET_CONTROL)) begin
      reset_control_reg <= WDATA_I & RESET_CONTROL_MASK;
    end
  end

  // ------------------------------------------------------------
  // interrupt wake-up, vector and return stack
  // ------------------------------------------------------------
  logic [7:0] interrupt_control_reg;
  logic [7:0] peripheral_flag_reg;
  logic [20:0] return_top_reg;
  logic [7:0] return_stack_pointer_reg;
  logic [20:0] pc_vector_reg;
  logic pc_load_reg;

  assign vec_wake = WAKE_INT_I && !cls_pwr && !cls_hard &&
                    (interrupt_control_reg[GIE_HIGH_BIT] ||
                     interrupt_control_reg[GIE_LOW_BIT]);

  always_ff @(posedge CLK_I) begin
    if (cls_pwr || cls_hard) begin
      interrupt_control_reg <= ALL_ZEROS;
    end else if (!cls_wake && wr(A_INT_CONTROL)) begin
      interrupt_control_reg <= WDATA_I;
    end
  end

  // a wake cause arriving with a software clear wins over the clear
  always_ff @(posedge CLK_I) begin
    if (cls_pwr || cls_hard) begin
      peripheral_flag_reg <= ALL_ZEROS;
    end else begin
      if (wr(A_PERIPH_FLAGS)) begin
        peripheral_flag_reg <= WDATA_I;
      end
      if (WAKE_INT_I) begin
        // an empty cause still leaves bit zero set to mark the wake
        peripheral_flag_reg <= (wr(A_PERIPH_FLAGS) ? WDATA_I :
            peripheral_flag_reg) | WAKE_CAUSE_I |
            {7'h00, ~|WAKE_CAUSE_I};
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (cls_pwr) begin
      return_top_reg <= '0;
      return_stack_pointer_reg <= return_stack_pointer_reg &
          {2'b11, 6'h00};
      if (RESET_I) begin
        return_stack_pointer_reg <= ALL_ZEROS;
      end
    end else if (cls_hard) begin
      return_top_reg <= '0;
      return_stack_pointer_reg <= ALL_ZEROS;
      return_stack_pointer_reg[SP_FULL_BIT] <= STACK_FULL_I;
      return_stack_pointer_reg[SP_UNDER_BIT] <= STACK_UNDER_I;
    end else if (vec_wake) begin
      return_top_reg <= PC_I;
      return_stack_pointer_reg[SP_W-1:0] <=
          return_stack_pointer_reg[SP_W-1:0] + 5'd1;
    end else if (!cls_wake) begin
      if (wr(A_RET_TOP_UPPER)) begin
        return_top_reg[20:16] <= WDATA_I[4:0];
      end
      if (wr(A_RET_TOP_HIGH)) begin
        return_top_reg[15:8] <= WDATA_I;
      end
      if (wr(A_RET_TOP_LOW)) begin
        return_top_reg[7:0] <= WDATA_I;
      end
      if (wr(A_RET_STACK_PTR)) begin
        return_stack_pointer_reg <= WDATA_I & RETURN_STACK_POINTER_MASK;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      pc_load_reg <= 1'b0;
      pc_vector_reg <= '0;
    end else begin
      pc_load_reg <= vec_wake;
      if (vec_wake) begin
        pc_vector_reg <= WAKE_HIGH_PRI_I ? VEC_HIGH : VEC_LOW;
      end
    end
  end

  assign PC_LOAD_O = pc_load_reg;
  assign PC_VECTOR_O = pc_vector_reg;

  // ------------------------------------------------------------
  // port A
  // ------------------------------------------------------------
  logic [7:0] pin_meta_reg;
  logic [7:0] pin_sync_reg;
  logic [7:0] port_a_latch_reg;
  logic [7:0] port_a_direction_reg;
  logic [7:0] port_a_mask;

  assign port_a_mask = OSC_PORT_PINS_I ? ALL_ONES :
                       PORT_A_LOW_MASK;

  always_ff @(posedge CLK_I) begin
    pin_meta_reg <= PORT_A_PINS_I;
    pin_sync_reg <= pin_meta_reg;
  end

  always_ff @(posedge CLK_I) begin
    if (cls_pwr || cls_hard) begin
      port_a_latch_reg <= ALL_ZEROS;
      port_a_direction_reg <= PORT_A_DIR_RESET;
    end else if (!cls_wake) begin
      if (wr(A_PORT_A_LATCH)) begin
        port_a_latch_reg <= WDATA_I;
      end
      if (wr(A_PORT_A_DIR)) begin
        port_a_direction_reg <= WDATA_I;
      end
    end
  end

  assign PORT_A_LATCH_O = port_a_latch_reg & port_a_mask;
  assign PORT_A_DIR_O = port_a_direction_reg | ~port_a_mask;

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  logic [7:0] rdata_next;
  logic [7:0] rdata_reg;

  always_comb begin
    rdata_next = ALL_ZEROS;
    case (ADDR_I)
      A_TIMER2_COUNT: rdata_next = timer2_count_reg;
      A_TIMER2_PERIOD: rdata_next = timer2_period_reg & PERIOD_MASK;
      A_TIMER0_CONTROL: rdata_next = timer0_control_reg;
      A_TIMER0_HIGH: rdata_next = timer0_count_high_reg;
      A_TIMER0_LOW: rdata_next = timer0_count_low_reg;
      A_TIMER1_CONTROL: rdata_next = timer1_control_reg;
      A_TIMER1_LOW: rdata_next = timer1_count_low_reg;
      A_TIMER1_HIGH: rdata_next = timer1_count_high_reg;
      A_SP_ADDRESS: rdata_next = serial_port_address_reg;
      A_SP_STATE: rdata_next = serial_port_state_reg;
      A_SP_CONTROL_ONE: rdata_next = serial_port_control_one_reg;
      A_SP_CONTROL_TWO: rdata_next = serial_port_control_two_reg;
      A_SP_BUFFER: rdata_next = serial_port_buffer_reg;
      A_CONV_CONTROL_ZERO: rdata_next = converter_control_zero_reg;
      A_CONV_CONTROL_ONE: rdata_next = converter_control_one_reg;
      A_CONV_CONTROL_TWO: rdata_next = converter_control_two_reg;
      A_CONV_RESULT_LOW: rdata_next = converter_result_low_reg;
      A_OSC_CONTROL: rdata_next = oscillator_control_reg;
      A_VDET_CONTROL: rdata_next = voltage_detect_control_reg;
      A_WDOG_CONTROL: rdata_next = watchdog_control_reg;
      A_RESET_CONTROL: rdata_next = reset_control_reg & RESET_CONTROL_MASK;
      A_INT_CONTROL: rdata_next = interrupt_control_reg;
      A_PERIPH_FLAGS: rdata_next = peripheral_flag_reg;
      A_RET_TOP_UPPER: rdata_next = {3'b000, return_top_reg[20:16]};
      A_RET_TOP_HIGH: rdata_next = return_top_reg[15:8];
      A_RET_TOP_LOW: rdata_next = return_top_reg[7:0];
      A_RET_STACK_PTR: rdata_next = return_stack_pointer_reg & RETURN_STACK_POINTER_MASK;
      A_PORT_A_PINS: rdata_next = pin_sync_reg & port_a_mask;
      A_PORT_A_LATCH: rdata_next = port_a_latch_reg & port_a_mask;
      A_PORT_A_DIR: rdata_next = port_a_direction_reg & port_a_mask;
      default: rdata_next = ALL_ZEROS;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      rdata_reg <= ALL_ZEROS;
    end else if (RE_I) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= ALL_ZEROS;
    end
  end

  assign RDATA_O = rdata_reg;

endmodule : rci_top

`default_nettype wire

// >>> rci_pkg.sv
/*
  Constants for the reset-class register initialiser: register indices,
  widths, reset patterns and vectors.
  Assumes the reset controller and core share CLK_I with this block.
*/
// Behaviour
// - timer2 count: ones, zeros, kept on wake
// - timer2 period: cleared at power-on, else sevens ones
// - timer0 control set on hard resets, kept on wake
// - timer0 high cleared on power-on and hard resets, kept on wake; low byte left alone
// - timer1 control cleared; hard resets clear bit six, kept on wake
// - timer1 low cleared at power-on; both kept otherwise
// - serial address, state, controls cleared on hard resets
// - serial buffer cleared only at power-on or brown-out
// - converter control one: power-on loads condition nibble
// - converter controls cleared; result low at power-on only
// - oscillator control patterns with condition bits
// - voltage detect control reloaded on hard resets
// - watchdog control bit cleared on hard resets
// - interrupt wake sets a cause flag
// - enabled interrupt wake loads vector into counter
// - vectored wake pushes counter, advances stack pointer
// - unimplemented bits read as zero
// - port A bits six, seven gated by oscillator mode
// - reset control bits record the reset cause
package rci_pkg;

  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PC_W = 21;
  localparam int unsigned SP_W = 5;

  // register indices
  localparam logic [4:0] A_TIMER2_COUNT = 5'h00;
  localparam logic [4:0] A_TIMER2_PERIOD = 5'h01;
  localparam logic [4:0] A_TIMER0_CONTROL = 5'h02;
  localparam logic [4:0] A_TIMER0_HIGH = 5'h03;
  localparam logic [4:0] A_TIMER0_LOW = 5'h04;
  localparam logic [4:0] A_TIMER1_CONTROL = 5'h05;
  localparam logic [4:0] A_TIMER1_LOW = 5'h06;
  localparam logic [4:0] A_TIMER1_HIGH = 5'h07;
  localparam logic [4:0] A_SP_ADDRESS = 5'h08;
  localparam logic [4:0] A_SP_STATE = 5'h09;
  localparam logic [4:0] A_SP_CONTROL_ONE = 5'h0A;
  localparam logic [4:0] A_SP_CONTROL_TWO = 5'h0B;
  localparam logic [4:0] A_SP_BUFFER = 5'h0C;
  localparam logic [4:0] A_CONV_CONTROL_ZERO = 5'h0D;
  localparam logic [4:0] A_CONV_CONTROL_ONE = 5'h0E;
  localparam logic [4:0] A_CONV_CONTROL_TWO = 5'h0F;
  localparam logic [4:0] A_CONV_RESULT_LOW = 5'h10;
  localparam logic [4:0] A_OSC_CONTROL = 5'h11;
  localparam logic [4:0] A_VDET_CONTROL = 5'h12;
  localparam logic [4:0] A_WDOG_CONTROL = 5'h13;
  localparam logic [4:0] A_RESET_CONTROL = 5'h14;
  localparam logic [4:0] A_INT_CONTROL = 5'h15;
  localparam logic [4:0] A_PERIPH_FLAGS = 5'h16;
  localparam logic [4:0] A_RET_TOP_UPPER = 5'h17;
  localparam logic [4:0] A_RET_TOP_HIGH = 5'h18;
  localparam logic [4:0] A_RET_TOP_LOW = 5'h19;
  localparam logic [4:0] A_RET_STACK_PTR = 5'h1A;
  localparam logic [4:0] A_PORT_A_PINS = 5'h1B;
  localparam logic [4:0] A_PORT_A_LATCH = 5'h1C;
  localparam logic [4:0] A_PORT_A_DIR = 5'h1D;

  // reset patterns
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] ALL_ZEROS = 8'h00;
  localparam logic [7:0] PERIOD_MASK = 8'h7F;
  localparam logic [7:0] SIX_BIT_MASK = 8'h3F;
  localparam logic [7:0] CONV2_MASK = 8'hBF;
  localparam logic [7:0] VDET_MASK = 8'hBF;
  localparam logic [7:0] VDET_RESET = 8'h05;
  localparam logic [7:0] WDOG_MASK = 8'h01;
  localparam logic [7:0] RESET_CONTROL_MASK = 8'hDF;
  localparam logic [7:0] TOP_UPPER_MASK = 8'h1F;
  localparam logic [7:0] RETURN_STACK_POINTER_MASK = 8'hDF;
  localparam logic [7:0] OSC_RESET = 8'h40;
  localparam logic [7:0] PORT_A_LOW_MASK = 8'h3F;
  localparam logic [7:0] PORT_A_DIR_RESET = 8'hFF;
  localparam int unsigned T1_CLEAR_BIT = 6;
  localparam int unsigned OSC_POR_Q_BIT = 3;
  localparam int unsigned OSC_HARD_Q_BIT = 1;
  localparam int unsigned GIE_HIGH_BIT = 7;
  localparam int unsigned GIE_LOW_BIT = 6;
  // reset control fields (active-low cause flags)
  localparam int unsigned RC_BOR_N = 0;
  localparam int unsigned RC_POR_N = 1;
  localparam int unsigned RC_PD_N = 2;
  localparam int unsigned RC_TO_N = 3;
  localparam int unsigned RC_RI_N = 4;
  localparam logic [7:0] RESET_CONTROL_POR = 8'h1C;
  localparam int unsigned SP_FULL_BIT = 7;
  localparam int unsigned SP_UNDER_BIT = 6;

  localparam logic [20:0] VEC_HIGH = 21'h00_0008;
  localparam logic [20:0] VEC_LOW = 21'h00_0018;

endpackage : rci_pkg

// >>> rci_checker.sv
/*
  Port-level assertions for the reset-class register initialiser.
  Assumes one clock, RESET_I synchronous active high, bound to rci_top.
*/
`timescale 1ns/1ns
`default_nettype none
module rci_checker import rci_pkg::*; (
  input wire logic CLK_I, RESET_I, POR_I, MASTER_CLEAR_I, WAKE_INT_I, RE_I,
  input wire logic WAKE_HIGH_PRI_I, OSC_PORT_PINS_I, PC_LOAD_O,
  input wire logic [rci_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [rci_pkg::DATA_W-1:0] RDATA_O, PORT_A_LATCH_O, PORT_A_DIR_O,
  input wire logic [rci_pkg::PC_W-1:0] PC_VECTOR_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  property p_rd_idle; !$past(RE_I) |-> RDATA_O == 8'h00; endproperty
  property p_pc_cause; PC_LOAD_O |-> $past(WAKE_INT_I); endproperty
  property p_pc_vec;
    PC_LOAD_O |-> PC_VECTOR_O == ($past(WAKE_HIGH_PRI_I) ? VEC_HIGH : VEC_LOW);
  endproperty
  property p_pc_pulse; PC_LOAD_O |=> !PC_LOAD_O; endproperty
  property p_vec_hold; !PC_LOAD_O |-> $stable(PC_VECTOR_O); endproperty
  property p_pa_gate;
    !OSC_PORT_PINS_I |-> PORT_A_LATCH_O[7:6] == 2'b00
      && PORT_A_DIR_O[7:6] == 2'b11;
  endproperty
  // read issued on the second edge after the class pulse
  property p_t2_por;
    $past(POR_I, 3) && $past(RE_I) && $past(ADDR_I) == A_TIMER2_COUNT
      |-> RDATA_O == ALL_ONES;
  endproperty
  property p_t0_hard;
    $past(MASTER_CLEAR_I, 3) && $past(RE_I) && $past(ADDR_I) == A_TIMER0_CONTROL
      |-> RDATA_O == ALL_ONES;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");
  a_pc_cause: assert property (p_pc_cause)
    else $error("counter load without interrupt wake");
  a_pc_vec: assert property (p_pc_vec)
    else $error("wrong wake vector");
  a_pc_pulse: assert property (p_pc_pulse)
    else $error("counter load longer than one cycle");
  a_vec_hold: assert property (p_vec_hold)
    else $error("vector moved without load");
  a_pa_gate: assert property (p_pa_gate)
    else $error("port a upper bits not gated");
  a_t2_por: assert property (p_t2_por)
    else $error("timer2 count not all ones after power-on");
  a_t0_hard: assert property (p_t0_hard)
    else $error("timer0 control not all ones after hard reset");
  c_load: cover property (PC_LOAD_O);
  c_por: cover property (POR_I);
  c_gate: cover property (!OSC_PORT_PINS_I && PORT_A_DIR_O[7:6] == 2'b11);
endmodule : rci_checker
bind rci_top rci_checker i_rci_checker (.CLK_I, .RESET_I, .POR_I, .MASTER_CLEAR_I,
  .WAKE_INT_I, .RE_I, .WAKE_HIGH_PRI_I, .OSC_PORT_PINS_I, .PC_LOAD_O, .ADDR_I,
  .RDATA_O, .PORT_A_LATCH_O, .PORT_A_DIR_O, .PC_VECTOR_O);
`default_nettype wire

// >>> tb.sv
/*
  Self-checking bench for rci_top: reset classes, wake-up, port A gating.
  Assumes rci_checker is bound beside the design.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  import rci_pkg::*;
  logic clk = 0, rst = 1, we = 0, re = 0, hp = 0, ppins = 0, oc = 1, ld;
  logic [3:0] cfg = 4'hA;
  logic [8:0] cls = '0;
  logic [7:0] wdata = '0, pins = 8'hFF, cause = '0, lat, dir, rdat;
  logic [4:0] addr = '0;
  logic [20:0] pc = '0, vec;
  int err_count = 0, checks_done = 0;
  // timer0 low and timer1 high have no power-on value: skipped there
  logic [7:0] por_tab [20] = '{8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0A, 8'h00,
    8'h00, 8'h48, 8'h05, 8'h00};
  logic [7:0] hard_tab [20] = '{8'h00, 8'h7F, 8'hFF, 8'h00, 8'hFF, 8'hBF,
    8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00,
    8'hFF, 8'h42, 8'h05, 8'h00};
  rci_top i_rci_top (.CLK_I(clk), .RESET_I(rst), .POR_I(cls[0]),
    .BOR_I(cls[1]), .MASTER_CLEAR_I(cls[2]), .WDT_RESET_I(cls[3]),
    .INSTR_RESET_I(cls[4]), .STACK_FULL_I(cls[5]), .STACK_UNDER_I(cls[6]),
    .WAKE_WDT_I(cls[7]), .WAKE_INT_I(cls[8]), .WAKE_CAUSE_I(cause),
    .WAKE_HIGH_PRI_I(hp), .PC_I(pc), .CONV_CFG_I(cfg), .OSC_POR_COND_I(oc),
    .OSC_RUN_COND_I(oc), .OSC_PORT_PINS_I(ppins), .SBOR_KEEP_I(1'b0),
    .PORT_A_PINS_I(pins), .PORT_A_LATCH_O(lat), .PORT_A_DIR_O(dir),
    .PC_LOAD_O(ld), .PC_VECTOR_O(vec), .ADDR_I(addr), .WDATA_I(wdata),
    .WE_I(we), .RE_I(re), .RDATA_O(rdat));
  initial forever #5 clk = ~clk;
  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [20:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 chk($sformatf("reg %h", a), rdat, e);
  endtask : rd
  task automatic pulse(input int k);
    @(posedge clk);
    cls[k] <= 1'b1;
    @(posedge clk);
    cls <= '0;
  endtask : pulse
  task automatic fill();
    for (int a = 0; a < 20; a++) wr(a[4:0], 8'hFF);
  endtask : fill
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_power(input int k);
    if (k >= 0) begin
      fill();
      pulse(k);
    end
    for (int a = 0; a < 20; a++)
      if (a != 4 && a != 7)
        rd(a[4:0], a == 14 ? {4'h0, cfg} : a == 17 ? {4'h4, oc, 3'h0} :
           por_tab[a]);
  endtask : t_power
  task automatic t_hard();
    for (int k = 2; k < 7; k++) begin
      fill();
      pulse(k);
      for (int a = 0; a < 20; a++)
        rd(a[4:0], a == 17 ? {6'h10, oc, 1'b0} :
           hard_tab[a]);
    end
  endtask : t_hard
  task automatic t_wake();
    fill();
    pulse(7);
    rd(A_TIMER2_COUNT, 8'hFF);
    rd(A_TIMER2_PERIOD, 8'h7F);
    rd(A_SP_BUFFER, 8'hFF);
    rd(A_VDET_CONTROL, 8'hBF);
    rd(A_WDOG_CONTROL, 8'h01);
    rd(A_TIMER0_HIGH, 8'hFF);
    rd(A_OSC_CONTROL, {6'h3F, oc, 1'b1});
    rd(A_RESET_CONTROL, 8'h12);
  endtask : t_wake
  task automatic t_int(input logic h, input logic [7:0] ie, input int sp);
    @(posedge clk);
    hp <= h;
    pc <= 21'h1_2345;
    cause <= 8'h04;
    wr(A_INT_CONTROL, ie);
    wr(A_PERIPH_FLAGS, 8'h00);
    pulse(8);
    #1 chk("pc load", ld, ie != 8'h00);
    if (ie != 8'h00) chk("vector", vec, h ? VEC_HIGH : VEC_LOW);
    rd(A_RET_STACK_PTR, sp[7:0]);
    rd(A_PERIPH_FLAGS, 8'h04);
  endtask : t_int
  task automatic t_port_a_pins(input logic en);
    @(posedge clk);
    ppins <= en;
    wr(A_PORT_A_LATCH, 8'hFF);
    wr(A_PORT_A_DIR, 8'h00);
    #1 chk("latch", lat, en ? 8'hFF : 8'h3F);
    chk("dir", dir, en ? 8'h00 : 8'hC0);
    rd(A_PORT_A_PINS, en ? 8'hFF : 8'h3F);
    rd(5'h1F, 8'h00);
  endtask : t_port_a_pins
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_power(-1);
    t_power(0);
    @(posedge clk);
    cfg <= 4'h5;
    oc <= 1'b0;
    t_power(1);
    rd(A_RESET_CONTROL, 8'h1E);
    t_hard();
    t_wake();
    pulse(2);
    rd(A_TIMER0_CONTROL, 8'hFF);
    t_int(1'b1, 8'h80, 1);
    rd(A_RET_TOP_UPPER, 8'h01);
    rd(A_RET_TOP_LOW, 8'h45);
    t_int(1'b0, 8'h40, 2);
    t_int(1'b1, 8'h00, 2);
    t_port_a_pins(1'b0);
    t_port_a_pins(1'b1);
    tally_and_finish();
  end
  initial begin
    #100000;
    err_count++;
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
